//--- inc/bsscr_pkg.sv
// package of offsets, field positions and reset values for the bridge status/control registers
package bsscr_pkg;
  // -----------------------------------------------------------------
  // register byte offsets in configuration space
  // -----------------------------------------------------------------
  localparam logic [7:0] SYS_CTRL_OFS = 8'h80;
  localparam logic [7:0] GEN_STATUS_OFS = 8'h85;
  localparam logic [7:0] GEN_CTRL_OFS = 8'h86;
  // -----------------------------------------------------------------
  // system control low half field positions
  // -----------------------------------------------------------------
  localparam int SC_RING_PME_PIN_SELECT_BIT = 0;
  localparam int SC_KEEP_BIT = 1;
  localparam int SC_VOLT_BIT = 2;
  localparam int SC_CDMA_BIT = 3;
  localparam int SC_PAR_BIT = 4;
  localparam int SC_SUBSYS_BIT = 5;
  localparam int SC_PSAVE_BIT = 6;
  localparam int SC_AUTOPWR_BIT = 7;
  localparam int SC_INTERR_BIT = 8;
  localparam int SC_DDOWN_BIT = 9;
  localparam int SC_DUP_BIT = 10;
  localparam int SC_PSTREAM_BIT = 11;
  localparam int SC_ONE_BIT = 12;
  localparam int SC_ACT_BIT = 13;
  localparam int SC_BURST_BIT = 14;
  // writable bits of the low byte and their reset value (lock bit set)
  localparam logic [7:0] SC_LOW_RESET = 8'h20;
  localparam logic SC_BURST_RESET = 1'b0;
  // -----------------------------------------------------------------
  // general status / control fields
  // -----------------------------------------------------------------
  localparam int GS_BUSY_BIT = 0;
  localparam int GS_ERR_BIT = 1;
  localparam int GS_DET_BIT = 2;
  localparam int GC_ARB_LSB = 0;
  localparam int GC_OFF_BIT = 3;
  localparam logic [1:0] GC_ARB_RESET = 2'h0;
  localparam logic GC_OFF_RESET = 1'b0;
  // arbitration policy codes
  localparam logic [1:0] ARB_HOST_CTRL = 2'h0;
  localparam logic [1:0] ARB_CARDBUS = 2'h1;
  // -----------------------------------------------------------------
  // power-stream sequencer states
  // -----------------------------------------------------------------
  typedef enum logic [3:0] {
    PS_IDLE = 4'b0001,
    PS_STREAM = 4'b0010,
    PS_DELAY_UP = 4'b0100,
    PS_DELAY_DN = 4'b1000
  } bsscr_pwr_state_t;
endpackage

//--- hdl/bsscr_pwr_seq.sv
// power-switch stream and settling delay status tracker
`timescale 1ns/10ps
module bsscr_pwr_seq (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic pwr_change_req_in,
  input wire logic pwr_up_in,
  input wire logic stream_done_in,
  input wire logic delay_done_in,
  output logic stream_busy_out,
  output logic up_busy_out,
  output logic down_busy_out
);
  bsscr_pkg::bsscr_pwr_state_t state_q;
  // -----------------------------------------------------------------
  // sequencer: stream, then up or down settling delay
  // -----------------------------------------------------------------
  // direction is latched at request so a late change cannot pick the wrong delay
  logic up_q;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      state_q <= bsscr_pkg::PS_IDLE;
      up_q <= 1'b0;
    end else begin
      unique case (state_q)
        bsscr_pkg::PS_IDLE: begin
          if (pwr_change_req_in) begin
            state_q <= bsscr_pkg::PS_STREAM;
            up_q <= pwr_up_in;
          end
        end
        bsscr_pkg::PS_STREAM: begin
          if (stream_done_in) begin
            state_q <= up_q ? bsscr_pkg::PS_DELAY_UP : bsscr_pkg::PS_DELAY_DN;
          end
        end
        bsscr_pkg::PS_DELAY_UP,
        bsscr_pkg::PS_DELAY_DN: begin
          if (delay_done_in) begin
            state_q <= bsscr_pkg::PS_IDLE;
          end
        end
        default: state_q <= bsscr_pkg::PS_IDLE;
      endcase
    end
  end
  // busy outputs are registered; one cycle behind the state
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      stream_busy_out <= 1'b0;
      up_busy_out <= 1'b0;
      down_busy_out <= 1'b0;
    end else begin
      stream_busy_out <= (state_q != bsscr_pkg::PS_IDLE);
      up_busy_out <= (state_q == bsscr_pkg::PS_DELAY_UP);
      down_busy_out <= (state_q == bsscr_pkg::PS_DELAY_DN);
    end
  end
endmodule

//--- hdl/bsscr_eeprom_stat.sv
// serial eeprom presence, error and busy status
`timescale 1ns/10ps
module bsscr_eeprom_stat (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic load_busy_in,
  input wire logic data_error_in,
  input wire logic err_clear_in,
  output logic present_out,
  output logic error_out,
  output logic busy_out
);
  // -----------------------------------------------------------------
  // presence strap: sampled by the clock while reset is held low
  // -----------------------------------------------------------------
  // last sample during reset stands after release
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      present_out <= scl_in;
    end
  end
  // sticky error; a new error wins over a write-one clear
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      error_out <= 1'b0;
    end else if (data_error_in) begin
      error_out <= 1'b1;
    end else if (err_clear_in) begin
      error_out <= 1'b0;
    end
  end
  // busy follows the loader, registered
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= load_busy_in;
    end
  end
endmodule

//--- hdl/bsscr_regs.sv
// configuration-space system control, general status and general control registers
// Functional notes
// - upstream read burst only when bit 14 set
// - activity flag sets on card access, read clears
// - bit 12 always reads one
// - stream busy until stream and delay done
// - power-up delay busy after up stream
// - power-down delay busy after down stream
// - bit 8 mirrors interrogation in progress
// - bit 7 gates legacy auto power switch
// - idle stopped cardbus card stops state clock
// - bit 5 locks subsystem id registers
// - bit 4 routes cardbus parity to serr
// - dma enabled only with bit and pins
// - legacy mode bit 2 picks 3.3/5 volts
// - bit 1 forbids clock stop via clkrun
// - bit 0 chooses ring/pme pin muxing
// - eeprom present if scl high in reset
// - eeprom error sticky, write one clears
// - eeprom busy while loading subsystem id
// - general status bits 7-3 read zero
// - bit 3 disables 1394 host controller
// - bits 1-0 pick arbitration policy
// - general control 7-4 and 2 zero
`timescale 1ns/10ps
module bsscr_regs (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // configuration access, byte address of the dword plus byte enables
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [3:0] cfg_be_in,
  input wire logic [31:0] cfg_wdata_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_rvalid_out,
  // status sources
  input wire logic card_access_in,
  input wire logic interrogating_in,
  input wire logic pwr_change_req_in,
  input wire logic pwr_up_in,
  input wire logic stream_done_in,
  input wire logic delay_done_in,
  input wire logic scl_in,
  input wire logic eeprom_load_in,
  input wire logic eeprom_data_err_in,
  // conditions for the controls
  input wire logic cb_card_idle_in,
  input wire logic cb_clk_stopped_in,
  input wire logic mfunc_dma_cfg_in,
  input wire logic legacy_mode_in,
  input wire logic cb_parity_err_in,
  input wire logic ring_req_in,
  input wire logic pme_req_in,
  input wire logic clkrun_stop_req_in,
  // controls driven to the rest of the bridge
  output logic upstream_read_burst_en_out,
  output logic auto_power_switch_en_out,
  output logic cb_state_clk_en_out,
  output logic subsystem_id_write_lock_out,
  output logic serr_req_out,
  output logic central_dma_en_out,
  output logic legacy_5v_sel_out,
  output logic clkrun_stop_allow_out,
  output logic ring_pme_pin_out,
  output logic host_ctrl_function_off_out,
  output logic [1:0] bus_arbitration_policy_out
);
  // -----------------------------------------------------------------
  // storage
  // -----------------------------------------------------------------
  logic [7:0] sc_low_q;
  logic burst_q;
  logic activity_q;
  logic interr_q;
  logic [1:0] arb_q;
  logic off_q;
  logic stream_busy;
  logic up_busy;
  logic down_busy;
  logic ee_present;
  logic ee_error;
  logic ee_busy;
  logic sc_hit;
  logic gs_hit;
  logic err_clear;
  logic act_read;

  assign sc_hit = (cfg_addr_in == bsscr_pkg::SYS_CTRL_OFS);
  // status and control byte share the dword at 84h
  assign gs_hit = (cfg_addr_in == (bsscr_pkg::GEN_STATUS_OFS & 8'hfc));
  // write one to the error bit clears it; only byte lane 1 reaches it
  assign err_clear = cfg_wr_in && gs_hit && cfg_be_in[1]
                     && cfg_wdata_in[8 + bsscr_pkg::GS_ERR_BIT];
  // a read of lane 1 of system control consumes the activity flag
  assign act_read = cfg_rd_in && sc_hit && cfg_be_in[1];

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  bsscr_pwr_seq u_pwr_seq (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .pwr_change_req_in(pwr_change_req_in),
    .pwr_up_in(pwr_up_in),
    .stream_done_in(stream_done_in),
    .delay_done_in(delay_done_in),
    .stream_busy_out(stream_busy),
    .up_busy_out(up_busy),
    .down_busy_out(down_busy)
  );

  bsscr_eeprom_stat u_eeprom (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .scl_in(scl_in),
    .load_busy_in(eeprom_load_in),
    .data_error_in(eeprom_data_err_in),
    .err_clear_in(err_clear),
    .present_out(ee_present),
    .error_out(ee_error),
    .busy_out(ee_busy)
  );

  // -----------------------------------------------------------------
  // writable system control bits
  // -----------------------------------------------------------------
  // only lane 0 and bit 14 are writable; status bits ignore writes
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      sc_low_q <= bsscr_pkg::SC_LOW_RESET;
      burst_q <= bsscr_pkg::SC_BURST_RESET;
    end else if (cfg_wr_in && sc_hit) begin
      if (cfg_be_in[0]) begin
        sc_low_q <= cfg_wdata_in[7:0];
      end
      if (cfg_be_in[1]) begin
        burst_q <= cfg_wdata_in[bsscr_pkg::SC_BURST_BIT];
      end
    end
  end

  // activity is sticky; a new access wins over the clearing read
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      activity_q <= 1'b0;
    end else if (card_access_in) begin
      activity_q <= 1'b1;
    end else if (act_read) begin
      activity_q <= 1'b0;
    end
  end

  // interrogation status registered from the socket logic
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      interr_q <= 1'b0;
    end else begin
      interr_q <= interrogating_in;
    end
  end

  // -----------------------------------------------------------------
  // general control byte (lane 2 of dword 84h)
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      arb_q <= bsscr_pkg::GC_ARB_RESET;
      off_q <= bsscr_pkg::GC_OFF_RESET;
    end else if (cfg_wr_in && gs_hit && cfg_be_in[2]) begin
      arb_q <= cfg_wdata_in[16 + bsscr_pkg::GC_ARB_LSB +: 2];
      off_q <= cfg_wdata_in[16 + bsscr_pkg::GC_OFF_BIT];
    end
  end

  // -----------------------------------------------------------------
  // read data, one cycle after the read strobe
  // -----------------------------------------------------------------
  // unmapped dwords read zero; the sampled value predates any clear
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      cfg_rdata_out <= 32'h0000_0000;
      cfg_rvalid_out <= 1'b0;
    end else begin
      cfg_rvalid_out <= cfg_rd_in;
      if (cfg_rd_in && sc_hit) begin
        cfg_rdata_out <= {17'h0_0000, burst_q, activity_q,
                          1'b1,
                          stream_busy, up_busy, down_busy, interr_q, sc_low_q};
      end else if (cfg_rd_in && gs_hit) begin
        cfg_rdata_out <= {8'h00,
                          4'h0, off_q, 1'b0, arb_q,
                          5'h00, ee_present, ee_error, ee_busy,
                          8'h00};
      end else if (cfg_rd_in) begin
        cfg_rdata_out <= 32'h0000_0000;
      end
    end
  end

  // -----------------------------------------------------------------
  // control outputs, all registered
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      upstream_read_burst_en_out <= 1'b0;
      auto_power_switch_en_out <= 1'b0;
      cb_state_clk_en_out <= 1'b1;
      subsystem_id_write_lock_out <= 1'b1;
      serr_req_out <= 1'b0;
      central_dma_en_out <= 1'b0;
      legacy_5v_sel_out <= 1'b0;
      clkrun_stop_allow_out <= 1'b0;
      ring_pme_pin_out <= 1'b0;
      host_ctrl_function_off_out <= 1'b0;
      bus_arbitration_policy_out <= bsscr_pkg::GC_ARB_RESET;
    end else begin
      upstream_read_burst_en_out <= burst_q;
      auto_power_switch_en_out <= sc_low_q[bsscr_pkg::SC_AUTOPWR_BIT];
      // gating only while idle and clockless, so a waking card is never missed
      cb_state_clk_en_out <= !(sc_low_q[bsscr_pkg::SC_PSAVE_BIT]
                               && cb_card_idle_in && cb_clk_stopped_in);
      subsystem_id_write_lock_out <= sc_low_q[bsscr_pkg::SC_SUBSYS_BIT];
      serr_req_out <= sc_low_q[bsscr_pkg::SC_PAR_BIT] && cb_parity_err_in;
      central_dma_en_out <= sc_low_q[bsscr_pkg::SC_CDMA_BIT]
                            && mfunc_dma_cfg_in;
      // outside legacy mode the voltage select is held at 3.3 V
      legacy_5v_sel_out <= legacy_mode_in && sc_low_q[bsscr_pkg::SC_VOLT_BIT];
      clkrun_stop_allow_out <= clkrun_stop_req_in
                               && !sc_low_q[bsscr_pkg::SC_KEEP_BIT];
      // bit 0 clear or-s ring with pme onto the pin; bit 0 set drives the pin from pme alone
      if (sc_low_q[bsscr_pkg::SC_RING_PME_PIN_SELECT_BIT]) begin
        ring_pme_pin_out <= pme_req_in;
      end else begin
        ring_pme_pin_out <= ring_req_in || pme_req_in;
      end
      host_ctrl_function_off_out <= off_q;
      bus_arbitration_policy_out <= arb_q;
    end
  end
endmodule

//--- testbench/bsscr_regs_props.sv
// port-level assertions for the bridge status and control registers
`timescale 1ns/10ps
module bsscr_regs_props (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [3:0] cfg_be_in,
  input wire logic [31:0] cfg_wdata_in,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic cfg_rvalid_out,
  input wire logic cb_card_idle_in,
  input wire logic cb_clk_stopped_in,
  input wire logic mfunc_dma_cfg_in,
  input wire logic cb_parity_err_in,
  input wire logic pme_req_in,
  input wire logic upstream_read_burst_en_out,
  input wire logic cb_state_clk_en_out,
  input wire logic subsystem_id_write_lock_out,
  input wire logic serr_req_out,
  input wire logic central_dma_en_out,
  input wire logic ring_pme_pin_out,
  input wire logic host_ctrl_function_off_out,
  input wire logic [1:0] bus_arbitration_policy_out
);
  // ---------------------------------------------------------------
  // writes land on the control pins two edges after the strobe
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);
  a_burst_write_lands: assert property (
    cfg_wr_in && cfg_addr_in == bsscr_pkg::SYS_CTRL_OFS && cfg_be_in[1] |->
    ##2 upstream_read_burst_en_out == $past(cfg_wdata_in[14], 2))
    else $error("burst enable did not follow write");
  a_lock_write_lands: assert property (
    cfg_wr_in && cfg_addr_in == bsscr_pkg::SYS_CTRL_OFS && cfg_be_in[0] |->
    ##2 subsystem_id_write_lock_out == $past(cfg_wdata_in[5], 2))
    else $error("write lock did not follow write");
  a_gc_write_lands: assert property (
    cfg_wr_in && cfg_addr_in == 8'h84 && cfg_be_in[2] |-> ##2
    {host_ctrl_function_off_out, bus_arbitration_policy_out} ==
    {$past(cfg_wdata_in[19], 2), $past(cfg_wdata_in[17:16], 2)})
    else $error("general control pins did not follow write");
  // ---------------------------------------------------------------
  // gated controls need their enabling condition one cycle before
  // ---------------------------------------------------------------
  a_serr_needs_parity: assert property (serr_req_out |-> $past(cb_parity_err_in))
    else $error("serr raised without parity error");
  a_dma_needs_pins: assert property (central_dma_en_out |-> $past(mfunc_dma_cfg_in))
    else $error("dma enabled without pin setup");
  a_pin_carries_pme: assert property (
    $past(rst_b_in) && $past(pme_req_in) |-> ring_pme_pin_out)
    else $error("pme request not on shared pin");
  a_clk_gate_cause: assert property (
    !cb_state_clk_en_out |-> $past(cb_card_idle_in && cb_clk_stopped_in))
    else $error("state clock stopped without idle stopped card");
  // ---------------------------------------------------------------
  // fixed and reserved read bits
  // ---------------------------------------------------------------
  a_sc_read_fixed: assert property (
    cfg_rvalid_out && $past(cfg_addr_in) == bsscr_pkg::SYS_CTRL_OFS |->
    cfg_rdata_out[12] && cfg_rdata_out[31:15] == 17'h0)
    else $error("system control fixed bits wrong");
  a_gsc_reserved_zero: assert property (
    cfg_rvalid_out && $past(cfg_addr_in) == 8'h84 |->
    cfg_rdata_out[15:11] == 5'h0 && cfg_rdata_out[23:20] == 4'h0 && !cfg_rdata_out[18])
    else $error("reserved status or control bits nonzero");
  a_unmapped_zero: assert property (
    cfg_rvalid_out && !($past(cfg_addr_in) inside {8'h80, 8'h84}) |-> cfg_rdata_out == 32'h0)
    else $error("unmapped read returned data");
  c_sys_read: cover property (cfg_rvalid_out && $past(cfg_addr_in) == 8'h80);
  c_serr: cover property (serr_req_out);
  c_clk_gated: cover property (!cb_state_clk_en_out);
endmodule

bind bsscr_regs bsscr_regs_props bsscr_regs_props_i (.clk_sys_in, .rst_b_in, .cfg_wr_in,
  .cfg_rd_in, .cfg_addr_in, .cfg_be_in, .cfg_wdata_in, .cfg_rdata_out, .cfg_rvalid_out,
  .cb_card_idle_in, .cb_clk_stopped_in, .mfunc_dma_cfg_in, .cb_parity_err_in, .pme_req_in,
  .upstream_read_burst_en_out, .cb_state_clk_en_out, .subsystem_id_write_lock_out,
  .serr_req_out, .central_dma_en_out, .ring_pme_pin_out, .host_ctrl_function_off_out,
  .bus_arbitration_policy_out);

//--- testbench/tb_bridge_system_status_control_regs.sv
// self-checking bench for the bridge status and control registers
`timescale 1ns/10ps
module tb_bridge_system_status_control_regs;
  logic clk_sys_in = 1'b0, rst_b_in = 1'b0, cfg_wr_in = 1'b0, cfg_rd_in = 1'b0;
  logic [7:0] cfg_addr_in = 8'h0;
  logic [3:0] cfg_be_in = 4'h0;
  logic [31:0] cfg_wdata_in = 32'h0, cfg_rdata_out, d;
  logic cfg_rvalid_out, upstream_read_burst_en_out, auto_power_switch_en_out;
  logic cb_state_clk_en_out, subsystem_id_write_lock_out, serr_req_out, central_dma_en_out;
  logic legacy_5v_sel_out, clkrun_stop_allow_out, ring_pme_pin_out, host_ctrl_function_off_out;
  logic [1:0] bus_arbitration_policy_out, arb = 2'h0;
  logic card_access_in = 1'b0, interrogating_in = 1'b0, pwr_change_req_in = 1'b0;
  logic pwr_up_in = 1'b0, stream_done_in = 1'b0, delay_done_in = 1'b0, scl_in = 1'b1;
  logic eeprom_load_in = 1'b0, eeprom_data_err_in = 1'b0, cb_card_idle_in = 1'b0;
  logic cb_clk_stopped_in = 1'b0, mfunc_dma_cfg_in = 1'b0, legacy_mode_in = 1'b0;
  logic cb_parity_err_in = 1'b0, ring_req_in = 1'b0, pme_req_in = 1'b0;
  logic clkrun_stop_req_in = 1'b0, b = 1'b0, off = 1'b0, pres = 1'b1;
  logic [7:0] lo = 8'h20;
  logic [31:0] exp_q[$];
  int num_errors = 0, tests_run = 0;
  integer seed = 32'hd4b7;

  bsscr_regs bsscr_regs_i (.clk_sys_in, .rst_b_in, .cfg_wr_in, .cfg_rd_in, .cfg_addr_in,
    .cfg_be_in, .cfg_wdata_in, .cfg_rdata_out, .cfg_rvalid_out, .card_access_in,
    .interrogating_in, .pwr_change_req_in, .pwr_up_in, .stream_done_in, .delay_done_in,
    .scl_in, .eeprom_load_in, .eeprom_data_err_in, .cb_card_idle_in, .cb_clk_stopped_in,
    .mfunc_dma_cfg_in, .legacy_mode_in, .cb_parity_err_in, .ring_req_in, .pme_req_in,
    .clkrun_stop_req_in, .upstream_read_burst_en_out, .auto_power_switch_en_out,
    .cb_state_clk_en_out, .subsystem_id_write_lock_out, .serr_req_out, .central_dma_en_out,
    .legacy_5v_sel_out, .clkrun_stop_allow_out, .ring_pme_pin_out,
    .host_ctrl_function_off_out, .bus_arbitration_policy_out);

  always #2.5 clk_sys_in = ~clk_sys_in;
  // ---------------------------------------------------------------
  // helpers: comparison, bus cycles and expected register images
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  // one-cycle strobes; the answer is noted before it can appear
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    step(1);
    cfg_rd_in = 1'b1;
    cfg_addr_in = a;
    cfg_be_in = 4'hf;
    exp_q.push_back(e);
    step(1);
    cfg_rd_in = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
    step(1);
    cfg_wr_in = 1'b1;
    cfg_addr_in = a;
    cfg_be_in = be;
    cfg_wdata_in = v;
    step(1);
    cfg_wr_in = 1'b0;
  endtask
  function automatic logic [31:0] sc(input logic [5:0] st);
    sc = {17'h0, b, st, lo};
  endfunction
  function automatic logic [31:0] gsc(input logic [1:0] st);
    gsc = {12'h0, off, 1'b0, arb, 5'h0, pres, st, 8'h0};
  endfunction
  // control pins as packed vector, model side worked from the register images
  function automatic logic [31:0] pins_exp();
    pins_exp = {20'h0, b, lo[7], !(lo[6] & cb_card_idle_in & cb_clk_stopped_in), lo[5],
      lo[4] & cb_parity_err_in, lo[3] & mfunc_dma_cfg_in, legacy_mode_in & lo[2],
      clkrun_stop_req_in & !lo[1], lo[0] ? pme_req_in : ring_req_in | pme_req_in, off, arb};
  endfunction
  task automatic check_pins();
    check({20'h0, upstream_read_burst_en_out, auto_power_switch_en_out, cb_state_clk_en_out,
      subsystem_id_write_lock_out, serr_req_out, central_dma_en_out, legacy_5v_sel_out,
      clkrun_stop_allow_out, ring_pme_pin_out, host_ctrl_function_off_out,
      bus_arbitration_policy_out}, pins_exp());
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // read answers are taken off the queue in arrival order
  always @(posedge clk_sys_in) begin
    if (cfg_rvalid_out === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("unexpected at %0t: seen %h expected none", $time, cfg_rdata_out);
      end else begin
        check(cfg_rdata_out, exp_q.pop_front());
      end
    end
  end
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    num_errors++;
    complete_run();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    step(6);
    rst_b_in = 1'b1;
    check_pins();
    rd(8'h80, sc(6'h10));
    rd(8'h84, gsc(2'h0));
    $display("reset values done");
    // random control values; odd passes present an idle stopped card
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      d[6] = i[1];
      cb_card_idle_in = i[0];
      cb_clk_stopped_in = i[0];
      {cb_parity_err_in, ring_req_in, pme_req_in, clkrun_stop_req_in} = d[31:28];
      {mfunc_dma_cfg_in, legacy_mode_in} = d[25:24];
      wr(8'h80, 4'h3, d);
      wr(8'h84, 4'h4, {12'h0, d[19:18], i[1:0], 16'h0});
      lo = d[7:0];
      b = d[14];
      off = d[19];
      arb = i[1:0];
      step(3);
      check_pins();
      rd(8'h80, sc(6'h10));
      rd(8'h84, gsc(2'h0));
    end
    $display("control pins done");
    card_access_in = 1'b1;
    step(1);
    card_access_in = 1'b0;
    rd(8'h80, sc(6'h30));
    rd(8'h80, sc(6'h10));
    interrogating_in = 1'b1;
    step(2);
    rd(8'h80, sc(6'h11));
    interrogating_in = 1'b0;
    step(2);
    rd(8'h80, sc(6'h10));
    $display("activity and interrogation done");
    // power change up then down: stream busy spans stream and delay
    for (int up = 1; up >= 0; up--) begin
      pwr_up_in = up[0];
      pwr_change_req_in = 1'b1;
      step(1);
      pwr_change_req_in = 1'b0;
      step(3);
      rd(8'h80, sc(6'h18));
      stream_done_in = 1'b1;
      step(1);
      stream_done_in = 1'b0;
      step(3);
      rd(8'h80, sc(up ? 6'h1c : 6'h1a));
      delay_done_in = 1'b1;
      step(1);
      delay_done_in = 1'b0;
      step(3);
      rd(8'h80, sc(6'h10));
    end
    $display("power sequence done");
    eeprom_load_in = 1'b1;
    step(2);
    rd(8'h84, gsc(2'h1));
    eeprom_load_in = 1'b0;
    eeprom_data_err_in = 1'b1;
    step(1);
    eeprom_data_err_in = 1'b0;
    step(2);
    rd(8'h84, gsc(2'h2));
    wr(8'h84, 4'h2, 32'h0000_fd00);
    rd(8'h84, gsc(2'h2));
    wr(8'h84, 4'h2, 32'h0000_0200);
    rd(8'h84, gsc(2'h0));
    wr(8'h88, 4'hf, 32'hffff_ffff);
    rd(8'h88, 32'h0);
    rd(8'h80, sc(6'h10));
    $display("eeprom status and unmapped done");
    // second reset with the clock line low: no eeprom seen
    rst_b_in = 1'b0;
    scl_in = 1'b0;
    step(6);
    rst_b_in = 1'b1;
    {lo, b, off, arb, pres} = {8'h20, 1'b0, 1'b0, 2'h0, 1'b0};
    rd(8'h84, gsc(2'h0));
    rd(8'h80, sc(6'h10));
    step(4);
    check(exp_q.size(), 32'h0);
    $display("second reset done");
    complete_run();
  end
endmodule
